/* File: dv/aux_supply_config_commands_assertions.sv */
// Wire-level checks on the auxiliary supply SPI link
`timescale 1ns/100ps
module aux_supply_config_commands_assertions
(
    input  wire logic mclk_i,
    input  wire logic srst_i,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic mosi,
    input  wire logic miso,
    input  wire logic miso_oe
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////
    // Link parks idle right after reset
    AST_RST_IDLE: assert property ($past(srst_i) |-> cs_n && !sck)
        else $error("link not idle after reset");
    // Mode 0: clock low outside a frame
    AST_SCK_IDLE: assert property (cs_n |-> !sck)
        else $error("sck high outside a frame");
    AST_FRAME_START: assert property ($fell(cs_n) |-> !sck)
        else $error("frame opened with sck high");
    // Each clock half lasts two system cycles
    AST_SCK_HIGH: assert property ($rose(sck) |=> sck ##1 !sck)
        else $error("sck high phase not two cycles");
    AST_SCK_LOW: assert property ($fell(sck) && !cs_n |=> !sck)
        else $error("sck low phase too short");
    // Data must not move while the receiver samples
    AST_MOSI_HOLD: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("mosi moved while sck high");
    AST_MISO_HOLD: assert property
        (miso_oe && sck && $past(sck) |-> $stable(miso))
        else $error("miso moved while sck high");
    // Device drives its data line only inside a frame
    AST_OE_FRAME: assert property (miso_oe |-> !cs_n)
        else $error("miso driven outside a frame");
    // Longest frame is opcode plus four bytes
    AST_FRAME_LEN: assert property ($fell(cs_n) |-> ##[1:200] cs_n)
        else $error("frame too long");
endmodule

/* File: dv/aux_supply_config_commands_test.sv */
// Self-checking bench for the auxiliary supply command link
`timescale 1ns/100ps
`include "aux_cmd_consts.svh"
module aux_supply_config_commands_test;
    typedef struct packed {logic [31:0] wr; logic [31:0] cfg;} row_t;
    logic        mclk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [1:0]  addr_i = 2'h0;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        strap_i = 1'b0;
    logic [31:0] rdata_o;
    logic        fhs_o, conv_o, en_o, byp_o, rat_o, loop_o, sleep_o, ready_o;
    logic [1:0]  drive_o;
    logic [7:0]  div_o;
    logic [6:0]  level_o;
    int          n_errors = 0;
    int          checks = 0;
    // Written value beside the value that must read back
    row_t        rows [8] = '{'{32'hffff_ffff, 32'h0001_dfff},
        '{32'h0000_0000, 32'h0000_0000}, '{32'h0000_6380, 32'h0000_4380},
        '{32'h0000_1400, 32'h0000_1400}, '{32'h0000_0d00, 32'h0000_0d00},
        '{32'hfffe_0600, 32'h0000_0600}, '{32'h0000_0100, 32'h0000_0100},
        '{32'h0001_0a55, 32'h0001_0a55}};

    always #50 mclk_i = ~mclk_i;

    aux_spi_if aux_spi_if_inst ();
    aux_cmd_device aux_cmd_device_inst (.mclk_i(mclk_i), .srst_i(srst_i),
        .spi(aux_spi_if_inst), .supply_mode_strap_i(strap_i),
        .fixed_high_supply_mode_o(fhs_o), .array_conv_en_o(conv_o),
        .aux_out_en_o(en_o), .aux_bypass_o(byp_o), .aux_ratio3_o(rat_o),
        .aux_drive_o(drive_o), .aux_div_o(div_o), .aux_level_o(level_o),
        .aux_closed_loop_o(loop_o), .sleep_o(sleep_o), .ready_o(ready_o));
    aux_cmd_host aux_cmd_host_inst (.mclk_i(mclk_i), .srst_i(srst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .spi(aux_spi_if_inst));
    aux_supply_config_commands_assertions chk_inst (.mclk_i(mclk_i),
        .srst_i(srst_i), .cs_n(aux_spi_if_inst.cs_n),
        .sck(aux_spi_if_inst.sck), .mosi(aux_spi_if_inst.mosi),
        .miso(aux_spi_if_inst.miso), .miso_oe(aux_spi_if_inst.miso_oe));
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strap is only caught after a reset, hence a reset per strap level
    task automatic do_reset(input logic strap);
        @(posedge mclk_i);
        srst_i <= 1'b1;
        strap_i <= strap;
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    // One frame; waits for the host to go idle, bounded
    task automatic frame(input logic [7:0] op, input logic [5:0] bits,
                         input logic [31:0] d);
        logic [31:0] s;
        if (bits == 6'd40)
            reg_wr(`CTL_REG_DATA, d);
        reg_wr(`CTL_REG_CMD, {18'h0, bits, op});
        for (int i = 0; i < 300; i++)
        begin
            reg_rd(`CTL_REG_STAT, s);
            if (i > 0 && s[0] === 1'b0)
                return;
        end
        n_errors++;
        finish_test();
    endtask
    task automatic get_stat(output logic [31:0] s);
        frame(`OP_STATUS_READ, 6'd16, 32'h0);
        reg_rd(`CTL_REG_RESULT, s);
    endtask
    task automatic get_cfg(output logic [31:0] c);
        logic [31:0] s;
        int i;
        frame(`OP_AUX_READ_PREP, 6'd8, 32'h0);
        for (i = 0; i < 20; i++)
        begin
            get_stat(s);
            if (s[0] === 1'b0)
                break;
        end
        check32({31'h0, 1'(i < 20)}, 32'h1);
        frame(`OP_RESPONSE_READ, 6'd40, 32'h0);
        reg_rd(`CTL_REG_RESULT, c);
    endtask
    task automatic check_pins(input logic [31:0] c);
        check32({19'h0, en_o, byp_o, rat_o, drive_o, loop_o, level_o},
                {19'h0, c[16:14], c[12:11], c[7:0]});
        check32({24'h0, div_o}, {24'h0, 8'h01 << c[10:8]});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [31:0] c;
        int k;
        do_reset(1'b0);
        check32({28'h0, fhs_o, conv_o, ready_o, sleep_o}, 32'ha);
        check32(rdata_o, 32'h0);
        check_pins(`AUX_RESET_VALUE);
        // Every drive and divide code goes through the volatile path
        foreach (rows[k])
        begin
            frame(`OP_AUX_VWRITE, 6'd40, rows[k].wr);
            get_cfg(c);
            check32(c, rows[k].cfg);
            check_pins(rows[k].cfg);
        end
        frame(`OP_AUX_PWRITE, 6'd40, 32'h0000_0123);
        get_cfg(c);
        check32(c, 32'h0001_0a55);
        frame(`OP_WRITE_ENABLE, 6'd8, 32'h0);
        get_stat(c);
        check32(c & 32'h2, 32'h2);
        frame(`OP_AUX_PWRITE, 6'd40, 32'h0001_c2ab);
        get_stat(c);
        check32(c & 32'h2, 32'h0);
        frame(`OP_AUX_VWRITE, 6'd40, 32'h0000_0000);
        // Persistent copy must come back after reset
        do_reset(1'b1);
        check32({28'h0, fhs_o, conv_o, ready_o, sleep_o}, 32'h6);
        get_cfg(c);
        check32(c, 32'h0001_c2ab);
        check_pins(32'h0001_c2ab);
        frame(`OP_SLEEP, 6'd8, 32'h0);
        check32({30'h0, sleep_o, en_o}, 32'h2);
        get_stat(c);
        check32(c & 32'h5, 32'h5);
        frame(`OP_AUX_VWRITE, 6'd40, 32'h0000_0000);
        frame(`OP_STANDBY, 6'd8, 32'h0);
        for (k = 0; k < 40 && ready_o !== 1'b1; k++)
            @(posedge mclk_i);
        check32({30'h0, 1'(k > 0), 1'(k < 40)}, 32'h3);
        check32({31'h0, sleep_o}, 32'h0);
        reg_rd(`CTL_REG_CMD, c);
        check32(c, {24'h0, `OP_STANDBY});
        get_cfg(c);
        check32(c, 32'h0001_c2ab);
        check_pins(c);
        finish_test();
    end
endmodule

/* File: verilog/aux_cmd_consts.svh */
// Constants for the auxiliary supply command link
`ifndef AUX_CMD_CONSTS_SVH
`define AUX_CMD_CONSTS_SVH
`define OP_STANDBY        8'he0
`define OP_SLEEP          8'he1
`define OP_WRITE_ENABLE   8'h06
`define OP_STATUS_READ    8'h05
`define OP_RESPONSE_READ  8'h15
`define OP_AUX_VWRITE     8'he5
`define OP_AUX_PWRITE     8'he6
`define OP_AUX_READ_PREP  8'he7
`define AUX_WRITABLE_MASK 32'h0001_dfff
`define AUX_RESET_VALUE   32'h0000_0000
`define AUX_EN_POS        16
`define AUX_BYP_POS       15
`define AUX_RATIO_POS     14
`define AUX_DRIVE_HI      12
`define AUX_DRIVE_LO      11
`define AUX_DIV_HI        10
`define AUX_DIV_LO        8
`define AUX_LOOP_POS      7
`define AUX_LEVEL_HI      6
`define AUX_LEVEL_LO      0
`define STAT_BUSY_N_POS   0
`define STAT_WEL_POS      1
`define STAT_SLEEP_POS    2
`define WAKE_CYCLES       8'h10
`define SCK_HALF_CYCLES   4'h2
`define CTL_REG_CMD       2'h0
`define CTL_REG_DATA      2'h1
`define CTL_REG_STAT      2'h2
`define CTL_REG_RESULT    2'h3
`endif

/* File: verilog/aux_cmd_device.sv */
// Device end: decodes auxiliary supply and standby commands
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`include "aux_cmd_consts.svh"
// Notes on behaviour
// - Opcode e0 requests standby
// - e5 plus four bytes, no enable needed
// - e6 needs prior write enable
// - Persistent copy loaded after every reset
// - e7 stages value, response read outputs
// - Bit16 enable, bit15 bypass, reset zero
// - Bit14 ratio two or three
// - Bits 12:11 drive strength quarters
// - Bits 10:8 clock divide power two
// - Bit7 closed loop regulation
// - Bits 6:0 comparator level
// - Strap low: fixed high supply, bypass
// - Strap high: wide range via converter
// - No auxiliary output during sleep
// - Host polls ready before response read
// - Standby from sleep ramps, then ready
module aux_cmd_device
    import aux_cmd_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    aux_spi_if.device       spi,
    input  wire logic       supply_mode_strap_i,
    output logic            fixed_high_supply_mode_o,
    output logic            array_conv_en_o,
    output logic            aux_out_en_o,
    output logic            aux_bypass_o,
    output logic            aux_ratio3_o,
    output logic [1:0]      aux_drive_o,
    output logic [7:0]      aux_div_o,
    output logic            aux_closed_loop_o,
    output logic [6:0]      aux_level_o,
    output logic            sleep_o,
    output logic            ready_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] aux_supply_settings_ff;
    logic [31:0] persist_ff = `AUX_RESET_VALUE; // Blank cells read zero
    logic [31:0] resp_ff;
    logic [31:0] data_ff;
    logic [31:0] shout_ff;
    logic        out_stat_ff;
    logic        out_armed_ff;
    logic [7:0]  opc_ff;
    logic [2:0]  nbytes_ff;
    logic [7:0]  wake_ff;
    logic        wel_ff;
    logic        sleep_ff;
    logic        sck_d_ff;
    logic        cs_d_ff;
    logic        fhs_ff;
    logic        strap_taken_ff;
    dev_state_t  state_ff;
    dev_state_t  nxt_state;
    logic        rise;
    logic        fall;
    logic        frame_end;
    logic [7:0]  rx_byte;
    logic        rx_full;
    logic [7:0]  stat_byte;
    logic [31:0] rx_word;
    ////////////////////////////////////////////////////////////////////////
    // Edge detection on link pins, sampled as synchronous inputs
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
        end
        else
        begin
            sck_d_ff <= spi.sck;
            cs_d_ff  <= spi.cs_n;
        end
    end
    assign rise      = !spi.cs_n && spi.sck && !sck_d_ff;
    assign fall      = !spi.cs_n && !spi.sck && sck_d_ff;
    assign frame_end = spi.cs_n && !cs_d_ff;

    aux_shift8 u_rx
    (
        .mclk_i     (mclk_i),
        .srst_i     (srst_i),
        .clr_i      (spi.cs_n),
        .step_i     (rise),
        .bit_i      (spi.mosi),
        .load_i     (1'b0),
        .load_val_i (8'h00),
        .byte_o     (rx_byte),
        .full_o     (rx_full)
    );
    // Byte just completed, including the bit arriving now
    logic [7:0] rx_now;
    assign rx_now  = {rx_byte[6:0], spi.mosi};
    assign rx_word = {data_ff[23:0], rx_now};

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode; sleep admits only standby, status and sleep
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            DEV_IDLE: if (!spi.cs_n) nxt_state = DEV_OPC;
            DEV_OPC:
                if (rx_full)
                begin
                    if (rx_now == `OP_AUX_VWRITE && !sleep_ff)
                        nxt_state = DEV_DATA;
                    else if (rx_now == `OP_AUX_PWRITE && !sleep_ff && wel_ff)
                        nxt_state = DEV_DATA;
                    else if (rx_now == `OP_STATUS_READ ||
                             (rx_now == `OP_RESPONSE_READ && !sleep_ff))
                        nxt_state = DEV_OUT;
                    else
                        nxt_state = DEV_SKIP;
                end
            DEV_DATA: if (rx_full && nbytes_ff == 3'h3) nxt_state = DEV_SKIP;
            DEV_OUT:  nxt_state = DEV_OUT;
            DEV_SKIP: nxt_state = DEV_SKIP;
            default:  nxt_state = DEV_IDLE;
        endcase
        if (spi.cs_n)
            nxt_state = DEV_IDLE;
    end
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            state_ff <= DEV_IDLE;
        else
            state_ff <= nxt_state;
    end
    // Latched opcode and data byte count
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            opc_ff    <= 8'h00;
            nbytes_ff <= 3'h0;
            data_ff   <= 32'h0;
        end
        else if (state_ff == DEV_OPC && rx_full)
        begin
            opc_ff    <= rx_now;
            nbytes_ff <= 3'h0;
        end
        else if (state_ff == DEV_DATA && rx_full)
        begin
            data_ff   <= rx_word;
            nbytes_ff <= nbytes_ff + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Persistent copy survives reset, standing in for non-volatile cells
    always_ff @(posedge mclk_i)
    begin
        if (state_ff == DEV_DATA && rx_full && nbytes_ff == 3'h3 &&
            opc_ff == `OP_AUX_PWRITE)
            persist_ff <= rx_word & `AUX_WRITABLE_MASK;
    end
    // Active settings: reset reloads the persistent copy
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            aux_supply_settings_ff <= persist_ff & `AUX_WRITABLE_MASK;
        else if (state_ff == DEV_DATA && rx_full && nbytes_ff == 3'h3)
            aux_supply_settings_ff <= rx_word & `AUX_WRITABLE_MASK;
    end
    // Write enable latch: set by its command, spent by persistent write
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            wel_ff <= 1'b0;
        else if (state_ff == DEV_OPC && rx_full && rx_now == `OP_WRITE_ENABLE
                 && !sleep_ff)
            wel_ff <= 1'b1;
        else if (frame_end && opc_ff == `OP_AUX_PWRITE)
            wel_ff <= 1'b0;
    end
    // Response buffer staged by read-prepare at frame end
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            resp_ff <= 32'h0;
        else if (frame_end && opc_ff == `OP_AUX_READ_PREP && !sleep_ff)
            resp_ff <= aux_supply_settings_ff;
    end
    ////////////////////////////////////////////////////////////////////////
    // Power mode and wake countdown; ready held off while ramping
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            sleep_ff <= 1'b0;
            wake_ff  <= 8'h00;
        end
        else if (frame_end && opc_ff == `OP_SLEEP && wake_ff == 8'h00)
            sleep_ff <= 1'b1;
        else if (frame_end && opc_ff == `OP_STANDBY && sleep_ff)
        begin
            sleep_ff <= 1'b0;
            wake_ff  <= `WAKE_CYCLES;
        end
        else if (wake_ff != 8'h00)
            wake_ff <= wake_ff - 8'h01;
    end
    assign ready_o = (wake_ff == 8'h00) && !sleep_ff;
    assign sleep_o = sleep_ff;
    // Strap caught once after reset release
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            fhs_ff         <= 1'b0;
            strap_taken_ff <= 1'b0;
        end
        else if (!strap_taken_ff)
        begin
            fhs_ff         <= !supply_mode_strap_i;
            strap_taken_ff <= 1'b1;
        end
    end
    assign fixed_high_supply_mode_o = fhs_ff;
    assign array_conv_en_o = strap_taken_ff && !fhs_ff;
    ////////////////////////////////////////////////////////////////////////
    // Field decode of active settings
    assign aux_out_en_o = aux_supply_settings_ff[`AUX_EN_POS] && !sleep_ff
                          && ready_o;
    assign aux_bypass_o = aux_supply_settings_ff[`AUX_BYP_POS];
    assign aux_ratio3_o = aux_supply_settings_ff[`AUX_RATIO_POS];
    assign aux_drive_o  =
        aux_supply_settings_ff[`AUX_DRIVE_HI:`AUX_DRIVE_LO];
    assign aux_div_o    = 8'h01 <<
        aux_supply_settings_ff[`AUX_DIV_HI:`AUX_DIV_LO];
    assign aux_closed_loop_o = aux_supply_settings_ff[`AUX_LOOP_POS];
    assign aux_level_o  =
        aux_supply_settings_ff[`AUX_LEVEL_HI:`AUX_LEVEL_LO];
    ////////////////////////////////////////////////////////////////////////
    // Status byte: bit0 busy (active low ready), bit1 enable latch, bit2 sleep
    assign stat_byte = {5'h00, sleep_ff, wel_ff, !ready_o};
    // Source picked at opcode end; loading on the first fall keeps miso
    // still while sck is high and the MSB is not shifted away unseen
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            out_stat_ff  <= 1'b0;
            out_armed_ff <= 1'b0;
        end
        else if (state_ff == DEV_OPC && rx_full)
        begin
            out_stat_ff  <= (rx_now == `OP_STATUS_READ);
            out_armed_ff <= 1'b0;
        end
        else if (state_ff == DEV_OUT && fall)
            out_armed_ff <= 1'b1;
    end
    // First fall places the MSB, later falls shift
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            shout_ff <= 32'h0;
        else if (state_ff == DEV_OUT && fall && !out_armed_ff)
            shout_ff <= out_stat_ff ? {stat_byte, 24'h0} : resp_ff;
        else if (state_ff == DEV_OUT && fall)
            shout_ff <= {shout_ff[30:0], 1'b0};
    end
    assign spi.miso    = shout_ff[31];
    assign spi.miso_oe = (state_ff == DEV_OUT) && !spi.cs_n;
endmodule

/* File: verilog/aux_cmd_host.sv */
// Host end: SPI controller driven by a small register port
`timescale 1ns/100ps
`include "aux_cmd_consts.svh"
module aux_cmd_host
    import aux_cmd_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    input  wire logic [1:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    aux_spi_if.host          spi
);
    logic [7:0]  opc_ff;
    logic [31:0] tx_ff;
    logic [31:0] rx_ff;
    logic [31:0] result_ff;
    logic [5:0]  bits_ff;
    logic [3:0]  half_ff;
    logic [3:0]  opc_left_ff;
    logic        sck_ff;
    logic        done_ff;
    host_state_t state_ff;
    logic        start;
    logic        half_end;
    assign start    = wr_i && addr_i == `CTL_REG_CMD && state_ff == HOST_IDLE;
    assign half_end = half_ff == `SCK_HALF_CYCLES - 4'h1;
    ////////////////////////////////////////////////////////////////////////
    // Command register: bits 7:0 opcode, 13:8 bit count incl. opcode
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            opc_ff <= 8'h00;
        else if (start)
            opc_ff <= wdata_i[7:0];
    end
    // Transfer sequencer; host must poll ready before response read
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            state_ff <= HOST_IDLE;
            bits_ff  <= 6'h0;
            half_ff  <= 4'h0;
            sck_ff   <= 1'b0;
            done_ff  <= 1'b0;
        end
        else
        begin
            case (state_ff)
                HOST_IDLE:
                    if (start)
                    begin
                        state_ff <= HOST_SHIFT;
                        bits_ff  <= wdata_i[13:8];
                        half_ff  <= 4'h0;
                        done_ff  <= 1'b0;
                    end
                HOST_SHIFT:
                    if (half_end)
                    begin
                        half_ff <= 4'h0;
                        sck_ff  <= !sck_ff;
                        if (sck_ff)
                        begin
                            bits_ff <= bits_ff - 6'h1;
                            if (bits_ff == 6'h1)
                                state_ff <= HOST_DONE;
                        end
                    end
                    else
                        half_ff <= half_ff + 4'h1;
                HOST_DONE:
                begin
                    state_ff <= HOST_IDLE;
                    done_ff  <= 1'b1;
                end
                default: state_ff <= HOST_IDLE;
            endcase
        end
    end
    // Outgoing data: opcode then data word, MSB first
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            tx_ff <= 32'h0;
        else if (wr_i && addr_i == `CTL_REG_DATA)
            tx_ff <= wdata_i;
        else if (start)
            tx_ff <= tx_ff;
        else if (state_ff == HOST_SHIFT && half_end && sck_ff &&
                 opc_left_ff == 4'h0)
            tx_ff <= {tx_ff[30:0], 1'b0};
    end
    // Opcode bits still to send; eight-bit frames never reach the data word
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            opc_left_ff <= 4'h0;
        else if (start)
            opc_left_ff <= 4'h8;
        else if (state_ff == HOST_SHIFT && half_end && sck_ff &&
                 opc_left_ff != 4'h0)
            opc_left_ff <= opc_left_ff - 4'h1;
    end
    logic [7:0] opc_sh_ff;
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            opc_sh_ff <= 8'h00;
        else if (start)
            opc_sh_ff <= wdata_i[7:0];
        else if (state_ff == HOST_SHIFT && half_end && sck_ff)
            opc_sh_ff <= {opc_sh_ff[6:0], 1'b0};
    end
    // Sample incoming bit on rising edge
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            rx_ff <= 32'h0;
        else if (state_ff == HOST_SHIFT && half_end && !sck_ff)
            rx_ff <= {rx_ff[30:0], spi.miso_oe ? spi.miso : 1'b0};
    end
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            result_ff <= 32'h0;
        else if (state_ff == HOST_DONE)
            result_ff <= rx_ff;
    end
    assign spi.cs_n = state_ff == HOST_IDLE;
    assign spi.sck  = sck_ff;
    assign spi.mosi = (opc_left_ff != 4'h0) ? opc_sh_ff[7] : tx_ff[31];
    ////////////////////////////////////////////////////////////////////////
    // Register read port, data one cycle after strobe
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            rdata_o <= 32'h0;
        else if (rd_i)
            case (addr_i)
                `CTL_REG_CMD:    rdata_o <= {24'h0, opc_ff};
                `CTL_REG_DATA:   rdata_o <= tx_ff;
                `CTL_REG_STAT:   rdata_o <= {30'h0, done_ff,
                                             state_ff != HOST_IDLE};
                `CTL_REG_RESULT: rdata_o <= result_ff;
                default:         rdata_o <= 32'h0;
            endcase
        else
            rdata_o <= 32'h0;
    end
endmodule

/* File: verilog/aux_cmd_pkg.sv */
// Types shared by both ends of the auxiliary supply command link
package aux_cmd_pkg;
    typedef enum logic [2:0]
    {
        DEV_IDLE = 3'b000,
        DEV_OPC  = 3'b001,
        DEV_DATA = 3'b011,
        DEV_OUT  = 3'b010,
        DEV_SKIP = 3'b110
    } dev_state_t;
    typedef enum logic [1:0]
    {
        HOST_IDLE = 2'b00,
        HOST_SHIFT = 2'b01,
        HOST_DONE = 2'b11
    } host_state_t;
endpackage

/* File: verilog/aux_shift8.sv */
// Byte shifter with bit counter, MSB first
`timescale 1ns/100ps
module aux_shift8
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       clr_i,
    input  wire logic       step_i,
    input  wire logic       bit_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_val_i,
    output logic      [7:0] byte_o,
    output logic            full_o
);
    logic [2:0] cnt_ff;
    // Shift register, load wins over shift
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            byte_o <= 8'h00;
        else if (load_i)
            byte_o <= load_val_i;
        else if (step_i)
            byte_o <= {byte_o[6:0], bit_i};
    end
    // Bit count; wraps at eight
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || clr_i)
            cnt_ff <= 3'h0;
        else if (step_i)
            cnt_ff <= cnt_ff + 3'h1;
    end
    assign full_o = step_i && (cnt_ff == 3'h7);
endmodule

/* File: verilog/aux_spi_if.sv */
// SPI link between host controller and auxiliary supply command decoder
`timescale 1ns/100ps
interface aux_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport device (input cs_n, input sck, input mosi,
                    output miso, output miso_oe);
    modport host (output cs_n, output sck, output mosi,
                  input miso, input miso_oe);
endinterface
